// [inc/cstd_defs.svh]
// field positions and register offsets of the descriptor decoder
`ifndef CSTD_DEFS_SVH
`define CSTD_DEFS_SVH
`define CSTD_DIR_BIT        16
`define CSTD_CYCLE_BIT      0
`define CSTD_EVAL_NEXT_BIT  1
`define CSTD_CHAIN_BIT      4
`define CSTD_COMPL_INT_BIT  5
`define CSTD_TYPE_HI        15
`define CSTD_TYPE_LO        10
`define CSTD_INTR_HI        31
`define CSTD_INTR_LO        22
`define CSTD_ISO_LEN_HI     16
`define CSTD_ISO_TBC_HI     21
`define CSTD_ISO_TBC_LO     17
`define CSTD_REG_DW0        4'h0
`define CSTD_REG_DW1        4'h1
`define CSTD_REG_DW2        4'h2
`define CSTD_REG_DW3        4'h3
`define CSTD_REG_CTRL       4'h4
`define CSTD_REG_STAT       4'h5
`define CSTD_REG_RESULT     4'h6
`define CSTD_REG_EVENT      4'h7
`define CSTD_REG_COMPL      4'h8
`define CSTD_TYPE_STATUS    6'h04
`define CSTD_TYPE_DATA      6'h03
`define CSTD_TYPE_ISOCH     6'h05
`endif

// [inc/cstd_pkg.sv]
// types of the descriptor decoder
package cstd_pkg;
    typedef struct packed {
        logic [9:0] intr_target;
        logic       cycle;
        logic       eval_next;
        logic       chain;
        logic       compl_int;
        logic       dir_in;
        logic [5:0] trb_type;
    } cstd_fields_type;
    typedef enum logic [1:0] {
        CSTD_IDLE,
        CSTD_NEXT,
        CSTD_DONE
    } cstd_state_type;
endpackage

// [src/cstd_decoder.sv]
// status-stage descriptor decoder with a classic wishbone slave
`timescale 1ns/1ps
`include "cstd_defs.svh"
module cstd_decoder #(
    parameter int INTR_COUNT = 8
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RESET,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    output logic             O_EVENT,
    output logic             O_IRQ_REQ,
    output logic             O_FETCH_NEXT
);
    logic [31:0] dw_q [4];
    logic [31:0] ctrl_q;
    logic [7:0]  compl_q;
    logic        ring_cycle_q;
    logic [31:0] event_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic        ev_q;
    logic        irq_q;
    logic        fetch_q;
    logic        valid_q;
    cstd_pkg::cstd_state_type state_q;
    cstd_pkg::cstd_fields_type f;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    wire        req      = i_wb_cyc && i_wb_stb && !ack_q;
    wire [3:0]  idx      = i_wb_adr[5:2];
    wire        wr       = req && i_wb_we;
    wire        wr_ctrl  = wr && (idx == `CSTD_REG_CTRL);
    // ctrl bit0 decodes the loaded descriptor, bit1 reports completion
    wire        go       = wr_ctrl && i_wb_dat[0] && i_wb_sel[0];
    wire        complete = wr_ctrl && i_wb_dat[1] && i_wb_sel[0];
    // reserved bits are never looked at
    // one driver for the whole struct, so no field is driven twice
    assign f = '{
        intr_target: dw_q[2][`CSTD_INTR_HI:`CSTD_INTR_LO],
        cycle:       dw_q[3][`CSTD_CYCLE_BIT],
        eval_next:   dw_q[3][`CSTD_EVAL_NEXT_BIT],
        chain:       dw_q[3][`CSTD_CHAIN_BIT],
        compl_int:   dw_q[3][`CSTD_COMPL_INT_BIT],
        dir_in:      dw_q[3][`CSTD_DIR_BIT],
        trb_type:    dw_q[3][`CSTD_TYPE_HI:`CSTD_TYPE_LO]
    };
    wire is_status  = f.trb_type == `CSTD_TYPE_STATUS;
    wire is_data    = f.trb_type == `CSTD_TYPE_DATA;
    wire is_isoch   = f.trb_type == `CSTD_TYPE_ISOCH;
    wire cycle_ok   = f.cycle == ring_cycle_q;
    wire intr_ok    = 32'(f.intr_target) < INTR_COUNT;
    wire known      = is_status || is_data || is_isoch;
    wire [31:0] result = {f.intr_target, 6'h00, dw_q[2][`CSTD_ISO_TBC_HI:`CSTD_ISO_TBC_LO],
                          is_isoch, is_data, is_status, intr_ok, cycle_ok,
                          f.dir_in, f.compl_int, f.chain, f.eval_next, valid_q, 1'b0};
    wire [31:0] stat   = {28'h0000000, ring_cycle_q, ev_q, fetch_q,
                          state_q == cstd_pkg::CSTD_NEXT};
    wire [31:0] rd_mux = (idx <= `CSTD_REG_DW3)    ? dw_q[idx[1:0]] :
                         (idx == `CSTD_REG_CTRL)   ? ctrl_q :
                         (idx == `CSTD_REG_STAT)   ? stat :
                         (idx == `CSTD_REG_RESULT) ? result :
                         (idx == `CSTD_REG_EVENT)  ? event_q :
                         (idx == `CSTD_REG_COMPL)  ? {24'h000000, compl_q} : 32'h00000000;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_dw
            always_ff @(posedge I_CLK or posedge I_RESET) begin
                if (I_RESET) begin
                    dw_q[g] <= 32'h00000000;
                end else if (wr && idx == 4'(g)) begin
                    dw_q[g] <= merge(dw_q[g], i_wb_dat, i_wb_sel);
                end
            end
        end
    endgenerate

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h00000000;
            ctrl_q <= 32'h00000000;
            compl_q <= 8'h00;
            ring_cycle_q <= 1'b1;
        end else begin
            ack_q  <= req;
            rdat_q <= req ? rd_mux : rdat_q;
            if (wr_ctrl) begin
                ctrl_q <= merge(ctrl_q, i_wb_dat, i_wb_sel) & 32'h00000004;
                ring_cycle_q <= i_wb_sel[0] ? i_wb_dat[2] : ring_cycle_q;
            end
            if (wr && idx == `CSTD_REG_COMPL && i_wb_sel[0]) begin
                compl_q <= i_wb_dat[7:0];
            end
        end
    end

    // event pulse only on the completion write, with compl_int set or a code other than 01
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            state_q <= cstd_pkg::CSTD_IDLE;
            valid_q <= 1'b0;
            fetch_q <= 1'b0;
            ev_q    <= 1'b0;
            irq_q   <= 1'b0;
            event_q <= 32'h00000000;
        end else begin
            ev_q  <= 1'b0;
            irq_q <= 1'b0;
            case (state_q)
                cstd_pkg::CSTD_IDLE: begin
                    if (go) begin
                        valid_q <= known && cycle_ok && intr_ok;
                        if (known && cycle_ok && f.eval_next) begin
                            fetch_q <= 1'b1;
                            state_q <= cstd_pkg::CSTD_NEXT;
                        end else if (known && cycle_ok) begin
                            state_q <= cstd_pkg::CSTD_DONE;
                        end
                    end
                end
                cstd_pkg::CSTD_NEXT: begin
                    // software reloads the next word then pulses go again
                    if (go) begin
                        fetch_q <= 1'b0;
                        state_q <= cstd_pkg::CSTD_DONE;
                    end
                end
                cstd_pkg::CSTD_DONE: begin
                    if (complete) begin
                        state_q <= cstd_pkg::CSTD_IDLE;
                        if (f.compl_int || compl_q != 8'h01) begin
                            ev_q    <= 1'b1;
                            irq_q   <= f.compl_int;
                            event_q <= {f.intr_target, 14'h0000, compl_q};
                        end
                    end
                end
                default: state_q <= cstd_pkg::CSTD_IDLE;
            endcase
        end
    end

    assign o_wb_dat     = rdat_q;
    assign o_wb_ack     = ack_q;
    assign O_EVENT      = ev_q;
    assign O_IRQ_REQ    = irq_q;
    assign O_FETCH_NEXT = fetch_q;
endmodule

// [tb/cstd_decoder_sva.sv]
// port assertions of the descriptor decoder
`timescale 1ns/1ps
module cstd_decoder_sva #(parameter int INTR_COUNT = 8) (
    input wire logic        I_CLK,
    input wire logic        I_RESET,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [3:0]  i_wb_sel,
    input wire logic [31:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic        O_EVENT,
    input wire logic        O_IRQ_REQ,
    input wire logic        O_FETCH_NEXT
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    wire req = i_wb_cyc && i_wb_stb;
    wire wr = req && i_wb_we;
    AST_ACK_NEXT: assert property (req && !o_wb_ack |=> o_wb_ack) else $error("ack late");
    AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
    AST_ACK_CAUSE: assert property (o_wb_ack |-> $past(req)) else $error("ack unasked");
    AST_DAT_HOLD: assert property (!req |=> $stable(o_wb_dat)) else $error("data moved");
    AST_IRQ_EVENT: assert property (O_IRQ_REQ |-> O_EVENT) else $error("lone irq");
    AST_EVENT_PULSE: assert property (O_EVENT |=> !O_EVENT) else $error("event held");
    AST_EVENT_CAUSE: assert property (O_EVENT |-> $past(wr)) else $error("event unasked");
    AST_FETCH_CAUSE: assert property ($changed(O_FETCH_NEXT) |-> $past(wr) || $past(wr, 2))
        else $error("fetch moved");
    cover property (O_IRQ_REQ);
    cover property (O_EVENT && !O_IRQ_REQ);
    cover property (O_FETCH_NEXT ##1 !O_FETCH_NEXT);
endmodule
bind cstd_decoder cstd_decoder_sva #(.INTR_COUNT(INTR_COUNT)) u_sva (.I_CLK(I_CLK),
    .I_RESET(I_RESET), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_sel(i_wb_sel), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .O_EVENT(O_EVENT), .O_IRQ_REQ(O_IRQ_REQ), .O_FETCH_NEXT(O_FETCH_NEXT));

// [tb/cstd_ring_model.sv]
// software side: status descriptor words built from fields
`timescale 1ns/1ps
module cstd_ring_model (
    input  wire cstd_pkg::cstd_fields_type i_fields,
    input  wire logic [1:0]                i_word,
    output logic [31:0]                    o_word
);
    always_comb begin
        case (i_word)
            2'h2: o_word = {i_fields.intr_target, 22'h0};
            2'h3: o_word = {15'h0, i_fields.dir_in, i_fields.trb_type, 4'h0, i_fields.compl_int,
                1'b0, 2'h0, i_fields.eval_next, i_fields.cycle};
            default: o_word = 32'h0;
        endcase
    end
endmodule

// [tb/testbench.sv]
// self-checking bench of the descriptor decoder
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] adr = 32'h0, dat = 32'h0, rdat, q, word, r;
    logic ack, ev, irq, fetch;
    logic [1:0] widx = 2'h0;
    logic [7:0] code;
    int seed = 32'h50eb, miscompares = 0, check_count = 0, n_ev = 0, n_irq = 0, e0, i0;
    cstd_pkg::cstd_fields_type f = '0;
    logic [5:0] types [4] = '{6'h03, 6'h04, 6'h05, 6'h07};
    always #4 clk = ~clk;
    always @(posedge clk) n_ev <= n_ev + int'(ev);
    always @(posedge clk) n_irq <= n_irq + int'(irq);
    cstd_decoder u_cstd_decoder (.I_CLK(clk), .I_RESET(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_sel(4'hf), .i_wb_adr(adr), .i_wb_dat(dat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .O_EVENT(ev), .O_IRQ_REQ(irq), .O_FETCH_NEXT(fetch));
    cstd_ring_model u_cstd_ring_model (.i_fields(f), .i_word(widx), .o_word(word));
    function automatic logic [31:0] exp_res(cstd_pkg::cstd_fields_type g);
        return {g.intr_target, 11'h0, g.trb_type == 6'h05, g.trb_type == 6'h03,
            g.trb_type == 6'h04, g.intr_target < 10'h8, 1'b1, g.dir_in, g.compl_int, 1'b0,
            g.eval_next, g.trb_type != 6'h07 && g.intr_target < 10'h8, 1'b0};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
            miscompares++;
        end
    endtask
    task wb(input logic w, input logic [3:0] idx, input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {26'h0, idx, 2'h0};
        dat <= d;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (k >= 20) miscompares++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #400000;
        miscompares++;
        print_verdict;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wb(1'b0, 4'hf, 32'h0);
        chk(q, 32'h0); // unmapped place reads zero
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            f = r[20:0];
            f.cycle = 1'b1;
            f.trb_type = types[i % 4];
            f.intr_target = (i == 0) ? 10'h3ff : {7'h0, f.intr_target[2:0]};
            code = (i % 3 == 0) ? 8'h01 : r[31:24];
            for (int w = 0; w < 4; w++) begin
                widx = w[1:0];
                @(posedge clk);
                wb(1'b1, w[3:0], word);
            end
            wb(1'b1, 4'h8, {24'h0, code});
            wb(1'b1, 4'h4, 32'h5);
            wb(1'b0, 4'h6, 32'h0);
            chk(q & 32'hffc0fffe, exp_res(f));
            chk({31'h0, fetch}, {31'h0, f.eval_next && f.trb_type != 6'h07});
            if (fetch === 1'b1) wb(1'b1, 4'h4, 32'h5);
            e0 = n_ev;
            i0 = n_irq;
            wb(1'b1, 4'h4, 32'h6);
            repeat (4) @(posedge clk);
            chk(32'(n_ev - e0), 32'(f.trb_type != 6'h07 && (f.compl_int || code != 8'h01)));
            chk(32'(n_irq - i0), {31'h0, f.compl_int && f.trb_type != 6'h07});
            wb(1'b0, 4'h7, 32'h0);
            if (n_ev != e0) chk(q & 32'hffc000ff, {f.intr_target, 14'h0, code});
            $display("test %0d done", i);
        end
        print_verdict;
    end
endmodule
